/* core/cmd_cfg.svh */
// Type codes, lengths and error bits of the short command handler.
// Assumes nothing; it only defines names.
`ifndef CMD_CFG_SVH
`define CMD_CFG_SVH

// Packet type codes carried in bits 5:0 of the identifier byte.
`define PT_VSYNC_START   6'h01
`define PT_VSYNC_END     6'h11
`define PT_HSYNC_START   6'h21
`define PT_HSYNC_END     6'h31
`define PT_COLOUR_REDUCE 6'h02
`define PT_COLOUR_NORMAL 6'h12
`define PT_SHUT_DOWN     6'h22
`define PT_TURN_ON       6'h32
`define PT_CMD_READ      6'h06
`define PT_SET_MAX_RET   6'h37

// Low three type bits that select the counted short packets.
`define PT_LO_GEN_WRITE  3'h3
`define PT_LO_GEN_READ   3'h4
`define PT_LO_CMD_WRITE  3'h5

// Low type nibbles that are reserved.
`define PT_RSVD_LO       4'h0
`define PT_RSVD_HI       4'hF

// Packet lengths in bytes, identifier and check byte included.
`define LEN_TWO          4'h2
`define LEN_CMD_READ     4'h3
`define LEN_SET_MAX      4'h4
`define LEN_EXTRA        4'h2

// Payload bytes held per packet and the width of the payload bus.
`define PAY_BYTES        7
`define PAY_W            56

// Error report bits.
`define ERR_W            3
`define ERR_CORRECTED    0
`define ERR_UNCORRECTED  1
`define ERR_BAD_TYPE     2

// Stored maximum return packet size after reset.
`define MAX_RET_RESET    16'h0001

`endif

/* core/cmd_pkg.sv */
// Types shared by the packet assembler and the command handler.
// Assumes cmd_cfg.svh is on the include path.
`include "cmd_cfg.svh"

package cmd_pkg;

  // Kind of response packet handed to the transmitter.
  typedef enum logic [1:0] {TX_ACK, TX_ERR_REPORT, TX_READ_DATA} tx_kind_t;

  // Phases of a bus turnaround answer.
  typedef enum logic [1:0] {RESP_IDLE, RESP_SEND, RESP_GIVE_BACK} resp_state_t;

endpackage : cmd_pkg

/* core/pkt_if.sv */
// Finished short packet passed from the assembler to the command handler.
// Assumes both ends run on the same byte clock.
`timescale 1ns/1ps

interface pkt_if;
  logic              done;       // One-cycle pulse, packet complete.
  logic              badType;    // Reserved type code seen.
  logic              corrected;  // Header check fixed a single bit.
  logic              bad;        // Header check found an uncorrectable error.
  logic [5:0]        pktType;
  logic [2:0]        count;      // Bytes between identifier and check byte.
  logic [`PAY_W-1:0] data;       // Byte 0 in bits 7:0.

  modport src (output done, badType, corrected, bad, pktType, count, data);
  modport dst (input  done, badType, corrected, bad, pktType, count, data);
endinterface : pkt_if

/* core/pkt_assembler.sv */
// Collects link bytes into short packets and reports each once.
// Assumes the link layer marks identifiers and checks headers.
`timescale 1ns/1ps

module pkt_assembler
  import cmd_pkg::*;
(
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       rst,
  // Received byte stream.
  input  wire logic       rxValid,
  input  wire logic       rxSop,
  input  wire logic [7:0] rxByte,
  input  wire logic       eccCorrected,
  input  wire logic       eccBad,
  // Finished packet.
  pkt_if.src              pkt
);

  typedef struct packed {
    logic              active;
    logic [3:0]        idx;
    logic [3:0]        len;
    logic              done;
    logic              badType;
    logic              corrected;
    logic              bad;
    logic [5:0]        pktType;
    logic [`PAY_W-1:0] data;
  } asm_state_t;

  asm_state_t r_reg;
  asm_state_t r_next;

  // Short packet length from its type; zero for long or unknown packets.
  function automatic logic [3:0] pktLen(input logic [5:0] dt);
    logic [3:0] len;
    len = 4'h0;
    if (dt[3:0] == 4'h1 || dt[3:0] == 4'h2) begin
      len = `LEN_TWO;                                            // R1 R2
    end else if (dt == `PT_CMD_READ) begin
      len = `LEN_CMD_READ;                                       // R22
    end else if (dt == `PT_SET_MAX_RET) begin
      len = `LEN_SET_MAX;
    end else if (dt[2:0] == `PT_LO_GEN_WRITE || dt[2:0] == `PT_LO_GEN_READ ||
                 dt[2:0] == `PT_LO_CMD_WRITE) begin
      len = {1'b0, dt[5:3]} + `LEN_EXTRA;                        // R10 R18
    end
    return len;
  endfunction : pktLen

  // Byte counting; long packets are skipped until the next identifier byte.
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (rxValid && rxSop) begin
      r_next.pktType   = rxByte[5:0];                           // R26
      r_next.len       = pktLen(rxByte[5:0]);
      r_next.idx       = 4'h1;
      r_next.data      = '0;
      r_next.active    = (r_next.len != 4'h0);
      r_next.badType   = (rxByte[3:0] == `PT_RSVD_LO) || (rxByte[3:0] == `PT_RSVD_HI);
      r_next.done      = r_next.badType;
      r_next.corrected = 1'b0;
      r_next.bad       = 1'b0;
    end else if (rxValid && r_reg.active) begin
      if (r_reg.idx == r_reg.len - 4'h1) begin
        r_next.done      = 1'b1;                                 // R19
        r_next.corrected = eccCorrected;
        r_next.bad       = eccBad;
        r_next.active    = 1'b0;
      end else begin
        for (int i = 0; i < `PAY_BYTES; i++) begin
          if (r_reg.idx == 4'(i + 1)) begin
            r_next.data[8*i +: 8] = rxByte;                      // R17
          end
        end
        r_next.idx = r_reg.idx + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Packet outputs come from the state register.
  assign pkt.done      = r_reg.done;
  assign pkt.badType   = r_reg.badType;
  assign pkt.corrected = r_reg.corrected;
  assign pkt.bad       = r_reg.bad;
  assign pkt.pktType   = r_reg.pktType;
  assign pkt.count     = 3'(r_reg.len - `LEN_EXTRA);
  assign pkt.data      = r_reg.data;

endmodule : pkt_assembler

/* core/short_cmd_handler.sv */
// Short command handler: decodes host short packets, answers turnarounds.
// Assumes a same-clock link layer that checks headers and sends responses.
`timescale 1ns/1ps

// Summary of operation
// (R1) Decode vertical end, horizontal start and end
// (R2) Decode vertical sync start event
// (R3) Vertical start opens period and starts line
// (R4) Vertical end also starts a line
// (R5) Host pairs start and end events
// (R6) Enter reduced colour mode
// (R7) Leave reduced colour mode
// (R8) Turn display off, receiver stays alive
// (R9) Turn display on
// (R10) Generic write, length from type bits
// (R11) Host ends generic read with turnaround
// (R12) Host splits oversize generic reads
// (R13) Generic read errors; corrected: data then report
// (R14) Clean read returns requested data
// (R15) Read request ends host transmission
// (R16) Answer, then return the bus
// (R17) Command byte then up to six parameters
// (R18) Type count holds parameters plus one
// (R19) Command-set write, one check byte last
// (R20) Command-set write answered with acknowledge
// (R21) One-way link ignores turnaround
// (R22) Command-set read carries one command byte
// (R23) Command-set read: report then data
// (R24) Host splits oversize command-set reads
// (R25) Maximum return size resets to one
// (R26) Identifier bits select the packet type
// (R27) Act only on checked headers
module short_cmd_handler
  import cmd_pkg::*;
(
  // Clock and reset.
  input  wire logic         mclk,
  input  wire logic         rst,
  // Received bytes from the link layer.
  input  wire logic         rxValid,
  input  wire logic         rxSop,
  input  wire logic [7:0]   rxByte,
  input  wire logic         eccCorrected,
  input  wire logic         eccBad,
  // Link control from the link layer and the board.
  input  wire logic         turnaroundIn,
  input  wire logic         biDirLink,
  input  wire logic         maxRetLoad,
  input  wire logic [15:0]  maxRetValue,
  // Display timing and power.
  output logic              vsyncStartPulse,
  output logic              vsyncEndPulse,
  output logic              hsyncStartPulse,
  output logic              hsyncEndPulse,
  output logic              lineStartPulse,
  output logic              vsyncActive,
  output logic              reducedColour,
  output logic              displayOn,
  // Write commands toward the application.
  output logic              wrValid,
  output logic              wrSet,
  output logic [2:0]        wrCount,
  output logic [`PAY_W-1:0] wrData,
  // Read requests toward the application.
  output logic              rdReq,
  output logic              rdSet,
  output logic [2:0]        rdCount,
  output logic [`PAY_W-1:0] rdData,
  output logic [15:0]       maxRetSize,
  // Response packets toward the transmitter.
  input  wire logic         txAck,
  output logic              txValid,
  output tx_kind_t          txKind,
  output logic [`ERR_W-1:0] txErr,
  output logic              busReturn
);

  typedef struct packed {
    resp_state_t       st;
    logic              vsS;
    logic              vsE;
    logic              hS;
    logic              hE;
    logic              lineStart;
    logic              vertical_sync_active_period;
    logic              red;
    logic              dispOn;
    logic              wrValid;
    logic              wrSet;
    logic [2:0]        wrCount;
    logic [`PAY_W-1:0] wrData;
    logic              rdReq;
    logic              rdSet;
    logic [2:0]        rdCount;
    logic [`PAY_W-1:0] rdData;
    logic              pendRead;
    logic              pendReadSet;
    logic              pendAck;
    logic [`ERR_W-1:0] errSeen;
    logic [15:0]       maxRet;
    logic              txValid;
    tx_kind_t          txKind;
    logic              hasSecond;
    tx_kind_t          second;
    logic [`ERR_W-1:0] txErr;
    logic              busReturn;
  } hdl_state_t;

  hdl_state_t r_reg;
  hdl_state_t r_next;

  pkt_if pkt ();

  // Byte assembly runs whatever the display power state is.
  pkt_assembler u_asm (                                          // R8
    .mclk         (mclk),
    .rst          (rst),
    .rxValid      (rxValid),
    .rxSop        (rxSop),
    .rxByte       (rxByte),
    .eccCorrected (eccCorrected),
    .eccBad       (eccBad),
    .pkt          (pkt)
  );

  // Packet decoding, state updates and the turnaround answer sequence.
  always_comb begin
    logic accept;
    accept = pkt.done && !pkt.bad && !pkt.badType;              // R27
    r_next = r_reg;
    r_next.vsS       = 1'b0;
    r_next.vsE       = 1'b0;
    r_next.hS        = 1'b0;
    r_next.hE        = 1'b0;
    r_next.lineStart = 1'b0;
    r_next.wrValid   = 1'b0;
    r_next.rdReq     = 1'b0;
    r_next.busReturn = 1'b0;

    // Errors are remembered until the next answer.
    if (pkt.done) begin
      r_next.errSeen[`ERR_CORRECTED]   = r_reg.errSeen[`ERR_CORRECTED] | pkt.corrected;
      r_next.errSeen[`ERR_UNCORRECTED] = r_reg.errSeen[`ERR_UNCORRECTED] | pkt.bad;
      r_next.errSeen[`ERR_BAD_TYPE]    = r_reg.errSeen[`ERR_BAD_TYPE] | pkt.badType;
    end

    // Command decode on the type field.
    if (accept) begin
      case (pkt.pktType)                                         // R26
        `PT_VSYNC_START: begin
          r_next.vsS       = 1'b1;                               // R2
          r_next.vertical_sync_active_period       = 1'b1;                               // R3
          r_next.lineStart = 1'b1;                               // R3
        end
        `PT_VSYNC_END: begin
          r_next.vsE       = 1'b1;                               // R1
          r_next.vertical_sync_active_period       = 1'b0;
          r_next.lineStart = 1'b1;                               // R4
        end
        `PT_HSYNC_START: begin
          r_next.hS        = 1'b1;                               // R1
          r_next.lineStart = 1'b1;
        end
        `PT_HSYNC_END:     r_next.hE     = 1'b1;                 // R1
        `PT_COLOUR_REDUCE: r_next.red    = 1'b1;                 // R6
        `PT_COLOUR_NORMAL: r_next.red    = 1'b0;                 // R7
        `PT_SHUT_DOWN:     r_next.dispOn = 1'b0;                 // R8
        `PT_TURN_ON:       r_next.dispOn = 1'b1;                 // R9
        `PT_CMD_READ: begin
          r_next.rdReq       = 1'b1;                             // R22
          r_next.rdSet       = 1'b1;
          r_next.rdCount     = pkt.count;
          r_next.rdData      = pkt.data;
          r_next.pendRead    = 1'b1;                             // R15
          r_next.pendReadSet = 1'b1;
        end
        default: begin
          if (pkt.pktType[2:0] == `PT_LO_GEN_WRITE) begin
            r_next.wrValid = 1'b1;                               // R10
            r_next.wrSet   = 1'b0;
            r_next.wrCount = pkt.count;
            r_next.wrData  = pkt.data;
          end else if (pkt.pktType[2:0] == `PT_LO_CMD_WRITE) begin
            r_next.wrValid = 1'b1;                               // R19
            r_next.wrSet   = 1'b1;
            r_next.wrCount = pkt.count;                          // R18
            r_next.wrData  = pkt.data;                           // R17
            r_next.pendAck = 1'b1;                               // R20
          end else if (pkt.pktType[2:0] == `PT_LO_GEN_READ) begin
            r_next.rdReq       = 1'b1;
            r_next.rdSet       = 1'b0;
            r_next.rdCount     = pkt.count;
            r_next.rdData      = pkt.data;
            r_next.pendRead    = 1'b1;                           // R11
            r_next.pendReadSet = 1'b0;
          end
        end
      endcase
    end

    // Stored return size limit, only meaningful on a two-way link.
    if (maxRetLoad && biDirLink) begin
      r_next.maxRet = maxRetValue;                               // R12 R24
    end

    // Answer sequence started by a turnaround.
    case (r_reg.st)
      RESP_IDLE: begin
        if (turnaroundIn && biDirLink) begin                     // R21
          r_next.txErr     = r_next.errSeen;
          r_next.hasSecond = 1'b0;
          r_next.st        = RESP_SEND;
          r_next.txValid   = 1'b1;
          if (r_next.pendRead && r_next.errSeen == 3'h1) begin
            r_next.hasSecond = 1'b1;
            if (r_next.pendReadSet) begin
              r_next.txKind = TX_ERR_REPORT;                     // R23
              r_next.second = TX_READ_DATA;
            end else begin
              r_next.txKind = TX_READ_DATA;                      // R13
              r_next.second = TX_ERR_REPORT;
            end
          end else if (r_next.pendRead && r_next.errSeen == 3'h0) begin
            r_next.txKind = TX_READ_DATA;                        // R14
          end else if (r_next.errSeen != 3'h0) begin
            r_next.txKind = TX_ERR_REPORT;                       // R13 R20 R23
          end else if (r_next.pendAck) begin
            r_next.txKind = TX_ACK;                              // R20
          end else begin
            r_next.txValid = 1'b0;
            r_next.st      = RESP_GIVE_BACK;
          end
        end
      end
      RESP_SEND: begin
        if (txAck) begin
          if (r_reg.hasSecond) begin
            r_next.txKind    = r_reg.second;
            r_next.hasSecond = 1'b0;
          end else begin
            r_next.txValid = 1'b0;
            r_next.st      = RESP_GIVE_BACK;
          end
        end
      end
      RESP_GIVE_BACK: begin
        r_next.busReturn = 1'b1;                                 // R16
        r_next.pendRead  = 1'b0;
        r_next.pendAck   = 1'b0;
        r_next.errSeen   = '0;
        r_next.st        = RESP_IDLE;
      end
      default: begin
        r_next.st      = RESP_IDLE;
        r_next.txValid = 1'b0;
      end
    endcase
  end

  // State register; the display starts on in full colour.
  always_ff @(posedge mclk) begin
    if (rst) begin
      r_reg        <= '0;
      r_reg.dispOn <= 1'b1;
      r_reg.maxRet <= `MAX_RET_RESET;                            // R25
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register.
  assign vsyncStartPulse = r_reg.vsS;
  assign vsyncEndPulse   = r_reg.vsE;
  assign hsyncStartPulse = r_reg.hS;
  assign hsyncEndPulse   = r_reg.hE;
  assign lineStartPulse  = r_reg.lineStart;
  assign vsyncActive     = r_reg.vertical_sync_active_period;
  assign reducedColour   = r_reg.red;
  assign displayOn       = r_reg.dispOn;
  assign wrValid         = r_reg.wrValid;
  assign wrSet           = r_reg.wrSet;
  assign wrCount         = r_reg.wrCount;
  assign wrData          = r_reg.wrData;
  assign rdReq           = r_reg.rdReq;
  assign rdSet           = r_reg.rdSet;
  assign rdCount         = r_reg.rdCount;
  assign rdData          = r_reg.rdData;
  assign maxRetSize      = r_reg.maxRet;
  assign txValid         = r_reg.txValid;
  assign txKind          = r_reg.txKind;
  assign txErr           = r_reg.txErr;
  assign busReturn       = r_reg.busReturn;

endmodule : short_cmd_handler

/* tb/short_cmd_handler_assertions.sv */
// Assertions on the short command handler's ports.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps

module short_cmd_handler_checker
  import cmd_pkg::*;
(
  // Clock and reset.
  input wire logic        mclk,
  input wire logic        rst,
  // Link side.
  input wire logic        rxValid,
  input wire logic        rxSop,
  input wire logic [7:0]  rxByte,
  input wire logic        eccBad,
  input wire logic        turnaroundIn,
  input wire logic        biDirLink,
  input wire logic        txAck,
  // Observed outputs.
  input wire logic        vsyncStartPulse,
  input wire logic        vsyncEndPulse,
  input wire logic        hsyncStartPulse,
  input wire logic        hsyncEndPulse,
  input wire logic        lineStartPulse,
  input wire logic        vsyncActive,
  input wire logic        reducedColour,
  input wire logic        displayOn,
  input wire logic        txValid,
  input wire tx_kind_t    txKind,
  input wire logic [2:0]  txErr,
  input wire logic        busReturn,
  input wire logic [15:0] maxRetSize
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // A two-byte packet of type t whose check byte carries error flag e.
  sequence s_two(logic [5:0] t, logic e);
    rxValid && rxSop && rxByte[5:0] == t ##1 rxValid && !rxSop && eccBad == e;
  endsequence
  // A response request that has just been withdrawn.
  sequence s_drop;
    txValid ##1 !txValid;
  endsequence

  // Sync events and the line starts they imply, two cycles after the check byte.
  property p_vstart; s_two(6'h01, 1'h0) |-> ##2 vsyncStartPulse && lineStartPulse && vsyncActive;
  endproperty
  a_vstart: assert property (p_vstart) else $error("vsync start");
  property p_vend; s_two(6'h11, 1'h0) |-> ##2 vsyncEndPulse && lineStartPulse && !vsyncActive;
  endproperty
  a_vend: assert property (p_vend) else $error("vsync end");
  property p_hstart; s_two(6'h21, 1'h0) |-> ##2 hsyncStartPulse && lineStartPulse; endproperty
  a_hstart: assert property (p_hstart) else $error("hsync start");
  property p_hend; s_two(6'h31, 1'h0) |-> ##2 hsyncEndPulse && !lineStartPulse; endproperty
  a_hend: assert property (p_hend) else $error("hsync end");
  property p_line; lineStartPulse |-> vsyncStartPulse || vsyncEndPulse || hsyncStartPulse;
  endproperty
  a_line: assert property (p_line) else $error("stray line start");

  // Display power and colour commands.
  property p_reduce; s_two(6'h02, 1'h0) |-> ##2 reducedColour; endproperty
  a_reduce: assert property (p_reduce) else $error("colour reduce");
  property p_normal; s_two(6'h12, 1'h0) |-> ##2 !reducedColour; endproperty
  a_normal: assert property (p_normal) else $error("colour normal");
  property p_off; s_two(6'h22, 1'h0) |-> ##2 !displayOn; endproperty
  a_off: assert property (p_off) else $error("shutdown");
  property p_on; s_two(6'h32, 1'h0) |-> ##2 displayOn; endproperty
  a_on: assert property (p_on) else $error("turn on");
  property p_bad; s_two(6'h22, 1'h1) |-> ##2 $stable(displayOn); endproperty
  a_bad: assert property (p_bad) else $error("acted on bad header");

  // Stored return size and the turnaround answer.
  property p_max_reset; $fell(rst) |-> maxRetSize == 16'h0001; endproperty
  a_max_reset: assert property (p_max_reset) else $error("max return reset");
  property p_one_way; turnaroundIn && !biDirLink && !txValid |=> (!txValid && !busReturn)[*3];
  endproperty
  a_one_way: assert property (p_one_way) else $error("turnaround used");
  property p_give_back; s_drop |=> busReturn; endproperty
  a_give_back: assert property (p_give_back) else $error("no bus return");
  property p_hold; txValid && !txAck |=> txValid && $stable(txKind) && $stable(txErr); endproperty
  a_hold: assert property (p_hold) else $error("response moved");
endmodule : short_cmd_handler_checker

/* tb/host_link_model.sv */
// Host model: sends packets, turns the bus, takes answers.
// Assumes the handler samples on the rising edge.
`timescale 1ns/1ps

module host_link_model (
  // Clock and answer pace.
  input  wire logic       mclk,
  input  wire logic [3:0] ackDly,
  // Link toward the handler.
  output logic            rxValid,
  output logic            rxSop,
  output logic [7:0]      rxByte,
  output logic            eccCorrected,
  output logic            eccBad,
  output logic            turnaroundIn,
  // Transmitter side.
  input  wire logic       txValid,
  output logic            txAck
);
  logic [3:0] waitCnt;

  // Idle link at time zero.
  initial begin
    rxValid = 1'h0;
    rxSop = 1'h0;
    rxByte = 8'h00;
    eccCorrected = 1'h0;
    eccBad = 1'h0;
    turnaroundIn = 1'h0;
    txAck = 1'h0;
    waitCnt = 4'h0;
  end

  // Sends n bytes, identifier first; check flags ride on the last byte.
  task automatic send(input int n, input logic [71:0] b, input logic c, input logic e);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      rxValid = 1'h1;
      rxSop = (i == 0);
      rxByte = b[8*i +: 8];
      eccCorrected = c && (i == n - 1);
      eccBad = e && (i == n - 1);
    end
    @(negedge mclk);
    rxValid = 1'h0;
    rxSop = 1'h0;
    rxByte = ~rxByte;
    eccCorrected = 1'h0;
    eccBad = 1'h0;
  endtask : send

  // Hands the bus over after the last packet of a transmission.
  task automatic turnaround();
    @(negedge mclk);
    turnaroundIn = 1'h1;
    @(negedge mclk);
    turnaroundIn = 1'h0;
  endtask : turnaround

  // Acknowledges each requested packet after ackDly waiting cycles.
  always @(negedge mclk) begin
    txAck <= 1'h0;
    if (txValid !== 1'h1 || txAck)
      waitCnt <= 4'h0;
    else if (waitCnt >= ackDly)
      txAck <= 1'h1;
    else
      waitCnt <= waitCnt + 4'h1;
  end
endmodule : host_link_model

/* tb/testbench.sv */
// Bench of the short command handler.
// Assumes the core files come first in one unit.
`timescale 1ns/1ps
`include "cmd_cfg.svh"

module testbench
  import cmd_pkg::*;
;
  logic              mclk, rst, biDirLink, maxRetLoad;
  logic [15:0]       maxRetValue, maxRetSize;
  logic [3:0]        ackDly;
  logic              rxValid, rxSop, eccCorrected, eccBad, turnaroundIn, txAck;
  logic [7:0]        rxByte;
  logic              vsyncStartPulse, vsyncEndPulse, hsyncStartPulse, hsyncEndPulse;
  logic              lineStartPulse, vsyncActive, reducedColour, displayOn;
  logic              wrValid, wrSet, rdReq, rdSet, txValid, busReturn;
  logic [2:0]        wrCount, rdCount, txErr, errSeen;
  logic [`PAY_W-1:0] wrData, rdData;
  tx_kind_t          txKind;
  tx_kind_t          kq[$];
  int                errorCnt = 0;
  int                comparisons = 0;

  // Byte clock of 100 ns period.
  initial mclk = 1'h0;
  always #50 mclk = ~mclk;

  short_cmd_handler DUT (.mclk, .rst, .rxValid, .rxSop, .rxByte, .eccCorrected, .eccBad,
    .turnaroundIn, .biDirLink, .maxRetLoad, .maxRetValue, .vsyncStartPulse, .vsyncEndPulse,
    .hsyncStartPulse, .hsyncEndPulse, .lineStartPulse, .vsyncActive, .reducedColour,
    .displayOn, .wrValid, .wrSet, .wrCount, .wrData, .rdReq, .rdSet, .rdCount, .rdData,
    .maxRetSize, .txAck, .txValid, .txKind, .txErr, .busReturn);
  host_link_model host (.mclk, .ackDly, .rxValid, .rxSop, .rxByte, .eccCorrected, .eccBad,
    .turnaroundIn, .txValid, .txAck);

  // Records each response packet as the transmitter takes it.
  always @(posedge mclk) begin
    if (txValid === 1'h1 && txAck === 1'h1) begin
      kq.push_back(txKind);
      if (txKind == TX_ERR_REPORT) errSeen = txErr;
    end
  end

  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Waits into the cycle in which decoded pulses stand.
  task settle();
    @(posedge mclk);
    #1;
  endtask : settle

  task pchk(input int n, input logic [71:0] b, input logic c, input logic r,
            input logic [3:0] e, input logic [55:0] d);
    host.send(n, b, c, 1'h0);
    settle();
    chk(r ? {rdReq, rdSet, rdCount, rdData} : {wrValid, wrSet, wrCount, wrData}, {1'h1, e, d});
  endtask : pchk

  // Hands the bus over and checks the answers.
  task bus_turnaround(input int n, input tx_kind_t k0, input tx_kind_t k1, input logic [2:0] e);
    int i;
    kq.delete();
    errSeen = 3'h0;
    host.turnaround();
    i = 0;
    while (busReturn !== 1'h1 && i < 60) begin
      @(negedge mclk);
      i++;
    end
    chk({i < 60, kq.size(), errSeen}, {1'h1, n, e});
    if (n > 0) chk(kq[0], k0);
    if (n > 1) chk(kq[1], k1);
  endtask : bus_turnaround

  task tSync();
    logic [5:0] st[4];
    logic [5:0] ex[4];
    st = '{6'h01, 6'h21, 6'h31, 6'h11};
    ex = '{6'h23, 6'h0B, 6'h05, 6'h12};
    for (int i = 0; i < 4; i++) begin
      host.send(2, {64'h0, 2'h0, st[i]}, 1'h0, 1'h0);
      settle();
      chk({vsyncStartPulse, vsyncEndPulse, hsyncStartPulse, hsyncEndPulse, lineStartPulse,
           vsyncActive}, ex[i]);
    end
  endtask : tSync

  task tPower();
    logic [5:0] st[4];
    logic [1:0] ex[4];
    st = '{6'h02, 6'h12, 6'h22, 6'h32};
    ex = '{2'h3, 2'h1, 2'h0, 2'h1};
    for (int i = 0; i < 4; i++) begin
      host.send(2, {64'h0, 2'h0, st[i]}, 1'h0, 1'h0);
      settle();
      chk({reducedColour, displayOn}, ex[i]);
    end
  endtask : tPower

  task tWrite();
    pchk(9, 72'h00_77_66_55_44_33_22_11_3B, 0, 0, 4'h7, 56'h77665544332211);
    pchk(3, 72'h00_9E_0B, 0, 0, 4'h1, 56'h9E);
    bus_turnaround(0, TX_ACK, TX_ACK, 3'h0);
    pchk(6, 72'h00_C3_B2_A1_2C_25, 0, 0, 4'hC, 56'hC3B2A12C);
    pchk(9, 72'h00_66_55_44_33_22_11_2C_3D, 0, 0, 4'hF, 56'h6655443322112C);
    bus_turnaround(1, TX_ACK, TX_ACK, 3'h0);
  endtask : tWrite

  task tRead();
    pchk(4, 72'h00_B2_A1_14, 0, 1, 4'h2, 56'hB2A1);
    bus_turnaround(1, TX_READ_DATA, TX_READ_DATA, 3'h0);
    pchk(3, 72'h00_77_0C, 1, 1, 4'h1, 56'h77);
    bus_turnaround(2, TX_READ_DATA, TX_ERR_REPORT, 3'h1);
    ackDly = 4'h6;
    pchk(3, 72'h00_DA_06, 1, 1, 4'h9, 56'hDA);
    bus_turnaround(2, TX_ERR_REPORT, TX_READ_DATA, 3'h1);
    ackDly = 4'h1;
  endtask : tRead

  task tErr();
    host.send(2, 72'h22, 1'h0, 1'h1);
    settle();
    chk(displayOn, 1'h1);
    bus_turnaround(1, TX_ERR_REPORT, TX_ERR_REPORT, 3'h2);
    host.send(2, 72'h30, 1'h0, 1'h0);
    bus_turnaround(1, TX_ERR_REPORT, TX_ERR_REPORT, 3'h4);
  endtask : tErr

  task tOneWay();
    logic seen;
    seen = 1'h0;
    biDirLink = 1'h0;
    maxRetLoad = 1'h1;
    maxRetValue = 16'h0040;
    @(negedge mclk);
    maxRetLoad = 1'h0;
    host.turnaround();
    repeat (6) begin
      @(negedge mclk);
      seen = seen | txValid | busReturn;
    end
    chk({seen, maxRetSize}, {1'h0, 16'h0001});
    biDirLink = 1'h1;
    maxRetLoad = 1'h1;
    @(negedge mclk);
    maxRetLoad = 1'h0;
    chk(maxRetSize, 16'h0040);
  endtask : tOneWay

  task conclude();
    if (errorCnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // Reset for four cycles, then each scenario in turn.
  initial begin
    rst = 1'h1;
    biDirLink = 1'h1;
    maxRetLoad = 1'h0;
    maxRetValue = 16'h0000;
    ackDly = 4'h1;
    repeat (4) @(negedge mclk);
    rst = 1'h0;
    chk({displayOn, reducedColour, txValid, maxRetSize}, {3'h4, 16'h0001});
    tSync();
    tPower();
    tWrite();
    tRead();
    tErr();
    tOneWay();
    conclude();
  end

  // Watchdog; the tests need under a thousand cycles.
  initial begin
    #200000;
    errorCnt++;
    conclude();
  end
endmodule : testbench

bind short_cmd_handler short_cmd_handler_checker assertChecker (.mclk, .rst, .rxValid, .rxSop,
  .rxByte, .eccBad, .turnaroundIn, .biDirLink, .txAck, .vsyncStartPulse, .vsyncEndPulse,
  .hsyncStartPulse, .hsyncEndPulse, .lineStartPulse, .vsyncActive, .reducedColour, .displayOn,
  .txValid, .txKind, .txErr, .busReturn, .maxRetSize);
